/* hdl/rsm_pkg.sv */
// Package for the radio status output mux: selector codes, field layout,
// reset values and clock divider figures.
// Assumes a single clock domain on the crystal oscillator clock.
package rsm_pkg;
   // Configuration byte layout
   localparam int SEL_LSB = 0;
   localparam int SEL_MSB = 5;
   localparam int INV_BIT = 6;
   localparam int TEMP_BIT = 7;
   // Reset values of the three configuration bytes, then the temperature sensor code
   localparam logic [7:0] PIN_A_CONFIG_RST = 8'h3f;
   localparam logic [7:0] PIN_B_CONFIG_RST = 8'h2e;
   localparam logic [7:0] PIN_C_CONFIG_RST = 8'h29;
   localparam logic [7:0] TEMP_SENSE_CODE = 8'h80;
   // Selector codes
   localparam logic [5:0] SEL_RX_THR = 6'h00;
   localparam logic [5:0] SEL_RX_THR_EOP = 6'h01;
   localparam logic [5:0] SEL_TX_THR = 6'h02;
   localparam logic [5:0] SEL_TX_FULL = 6'h03;
   localparam logic [5:0] SEL_RX_OVF = 6'h04;
   localparam logic [5:0] SEL_TX_UNF = 6'h05;
   localparam logic [5:0] SEL_SYNC = 6'h06;
   localparam logic [5:0] SEL_CRC_PKT = 6'h07;
   localparam logic [5:0] SEL_PQ = 6'h08;
   localparam logic [5:0] SEL_CCA = 6'h09;
   localparam logic [5:0] SEL_LOCK = 6'h0a;
   localparam logic [5:0] SEL_SER_CLK = 6'h0b;
   localparam logic [5:0] SEL_SYNC_DATA = 6'h0c;
   localparam logic [5:0] SEL_ASYNC_DATA = 6'h0d;
   localparam logic [5:0] SEL_CARRIER = 6'h0e;
   localparam logic [5:0] SEL_CRC_OK = 6'h0f;
   localparam logic [5:0] SEL_CHIP_RDY = 6'h29;
   localparam logic [5:0] SEL_HI_Z = 6'h2e;
   localparam logic [5:0] SEL_CONST = 6'h2f;
   localparam logic [5:0] SEL_CLK_DIV = 6'h3f;
   localparam logic [5:0] SLEEP_FORCE_LIMIT = 6'h20;
   // Divided crystal clock output
   localparam int CLK_DIV_RATIO = 192;
   localparam int CLK_HALF_COUNT = CLK_DIV_RATIO / 2;
endpackage

/* hdl/rsm_pin_mux.sv */
// One output pin of the status mux: selection, inversion, sleep forcing
// and enable. Assumes all inputs are already on clk.
`timescale 1ns/1ps
module rsm_pin_mux
   import rsm_pkg::*;
#(
   parameter logic SLEEP_LEVEL_INV = 1'b0,
   parameter logic [7:0] CONFIG_RST = 8'h00
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] config_in,
   input wire logic sleep_hold,
   input wire logic [15:0] src_vec,
   input wire logic chip_ready_low,
   input wire logic clk_div_out,
   output logic pin_out,
   output logic pin_oe,
   output logic temp_sense_en
);
   wire logic [5:0] sel = config_in[SEL_MSB:SEL_LSB];
   wire logic inv = config_in[INV_BIT];
   wire logic low_code = sel < SLEEP_FORCE_LIMIT;
   wire logic temp_mode = config_in == TEMP_SENSE_CODE;
   logic raw;
   logic drive;

   // Source selection; undefined codes stay low and touch nothing else
   always_comb
   begin
      raw = 1'b0;
      drive = 1'b1;
      if (low_code)
      begin
         raw = src_vec[sel[3:0]] & ~sel[4];
      end
      else
      begin
         unique case (sel)
            SEL_CHIP_RDY: raw = chip_ready_low;
            SEL_HI_Z: drive = 1'b0;
            SEL_CONST: raw = 1'b0;
            SEL_CLK_DIV: raw = clk_div_out;
            default: raw = 1'b0;
         endcase
      end
   end

   // Registered so the pin never glitches between sources
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         pin_out <= CONFIG_RST[INV_BIT];
         pin_oe <= CONFIG_RST[SEL_MSB:SEL_LSB] != SEL_HI_Z;
         temp_sense_en <= 1'b0;
      end
      else
      begin
         temp_sense_en <= temp_mode;
         pin_oe <= drive & ~temp_mode;
         if (sleep_hold && low_code)
            pin_out <= inv ^ SLEEP_LEVEL_INV;
         else
            pin_out <= raw ^ inv;
      end
   end
endmodule

/* hdl/rsm_top.sv */
// Top of the radio status output mux. Holds the sticky event flags, the
// crystal clock divider and three pin instances.
// Assumes radio status inputs come from logic on clk; only chip_ready_low
// and chip_select_low arrive from pins and are synchronised here.
`timescale 1ns/1ps
module rsm_top
   import rsm_pkg::*;
#(
   parameter int DIV_RATIO = CLK_DIV_RATIO
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] pin_a_config,
   input wire logic [7:0] pin_b_config,
   input wire logic [7:0] pin_c_config,
   input wire logic sleep_state,
   input wire logic chip_ready_low,
   input wire logic chip_select_low,
   input wire logic rx_fifo_at_thr,
   input wire logic rx_fifo_empty,
   input wire logic rx_end_of_packet,
   input wire logic rx_fifo_overflow,
   input wire logic rx_fifo_flush,
   input wire logic rx_fifo_first_read,
   input wire logic tx_fifo_at_thr,
   input wire logic tx_fifo_full,
   input wire logic tx_fifo_underflow,
   input wire logic tx_fifo_flush,
   input wire logic sync_word_done,
   input wire logic packet_end,
   input wire logic addr_check_fail,
   input wire logic tx_mode,
   input wire logic crc_compare_done,
   input wire logic crc_match,
   input wire logic rx_mode_enter,
   input wire logic legacy_compat_enable,
   input wire logic [7:0] preamble_quality,
   input wire logic [7:0] preamble_quality_threshold,
   input wire logic rssi_below_thr,
   input wire logic [1:0] clear_channel_mode,
   input wire logic receiving_packet,
   input wire logic rssi_above_cs,
   input wire logic synth_lock,
   input wire logic serial_clk,
   input wire logic serial_sync_data,
   input wire logic serial_async_data,
   output logic gp_out_a,
   output logic gp_out_a_oe,
   output logic gp_out_b,
   output logic gp_out_b_oe,
   output logic gp_out_c,
   output logic gp_out_c_oe,
   output logic temp_sensor_en,
   output logic pin_b_valid
);
   // The divider counts half periods, so odd or tiny ratios cannot be served
   if (DIV_RATIO < 4 || DIV_RATIO % 2 != 0)
   begin : g_bad_ratio
      $error("DIV_RATIO must be even and at least 4");
   end

   localparam int HALF = DIV_RATIO / 2;
   localparam int CW = $clog2(HALF);

   // Pin inputs pass two flip-flops before use
   logic rdy_meta_reg;
   logic rdy_sync_reg;
   logic cs_meta_reg;
   logic cs_sync_reg;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rdy_meta_reg <= 1'b1;
         rdy_sync_reg <= 1'b1;
         cs_meta_reg <= 1'b1;
         cs_sync_reg <= 1'b1;
      end
      else
      begin
         rdy_meta_reg <= chip_ready_low;
         rdy_sync_reg <= rdy_meta_reg;
         cs_meta_reg <= chip_select_low;
         cs_sync_reg <= cs_meta_reg;
      end
   end

   // Pin b shares the serial data line; flag when its value may be trusted
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pin_b_valid <= 1'b0;
      else
         pin_b_valid <= cs_sync_reg;
   end

   // Sleep forcing holds from sleep until chip ready falls, not on wake
   logic sleep_hold_reg;
   logic sleep_hold_next;
   assign sleep_hold_next = sleep_state ? 1'b1 :
                            (rdy_sync_reg ? sleep_hold_reg : 1'b0);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sleep_hold_reg <= 1'b0;
      else
         sleep_hold_reg <= sleep_hold_next;
   end

   // Crystal clock divider; toggles every half period for a 50 % duty
   logic [CW-1:0] div_cnt_reg;
   logic div_clk_reg;
   wire logic div_wrap = div_cnt_reg == CW'(HALF - 1);
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         div_cnt_reg <= '0;
         div_clk_reg <= 1'b0;
      end
      else if (div_wrap)
      begin
         div_cnt_reg <= '0;
         div_clk_reg <= ~div_clk_reg;
      end
      else
      begin
         div_cnt_reg <= div_cnt_reg + CW'(1);
      end
   end

   // Sticky event flags; a set in the same cycle as its clear wins
   logic rx_thr_eop_reg;
   logic tx_full_reg;
   logic rx_ovf_reg;
   logic tx_unf_reg;
   logic sync_reg;
   logic crc_pkt_reg;
   logic crc_ok_reg;
   wire logic rx_thr_eop_set = rx_fifo_at_thr | rx_end_of_packet;
   wire logic sync_abort = packet_end |
                           (~tx_mode & (addr_check_fail | rx_fifo_overflow))
                           | (tx_mode & tx_fifo_underflow);
   wire logic crc_pkt_set = rx_end_of_packet & crc_match;
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rx_thr_eop_reg <= 1'b0;
         tx_full_reg <= 1'b0;
         rx_ovf_reg <= 1'b0;
         tx_unf_reg <= 1'b0;
         sync_reg <= 1'b0;
         crc_pkt_reg <= 1'b0;
         crc_ok_reg <= 1'b0;
      end
      else
      begin
         if (rx_thr_eop_set)
            rx_thr_eop_reg <= 1'b1;
         else if (rx_fifo_empty)
            rx_thr_eop_reg <= 1'b0;
         if (tx_fifo_full)
            tx_full_reg <= 1'b1;
         else if (!tx_fifo_at_thr)
            tx_full_reg <= 1'b0;
         if (rx_fifo_overflow)
            rx_ovf_reg <= 1'b1;
         else if (rx_fifo_flush)
            rx_ovf_reg <= 1'b0;
         if (tx_fifo_underflow)
            tx_unf_reg <= 1'b1;
         else if (tx_fifo_flush)
            tx_unf_reg <= 1'b0;
         if (sync_word_done)
            sync_reg <= 1'b1;
         else if (sync_abort)
            sync_reg <= 1'b0;
         if (crc_pkt_set)
            crc_pkt_reg <= 1'b1;
         else if (rx_fifo_first_read)
            crc_pkt_reg <= 1'b0;
         if (crc_compare_done)
            crc_ok_reg <= crc_match;
         else if (rx_mode_enter)
            crc_ok_reg <= 1'b0;
      end
   end

   // Clear channel qualified by mode: 0 always, 1 rssi, 2 no packet, 3 both
   logic cca_level;
   always_comb
   begin
      unique case (clear_channel_mode)
         2'b00: cca_level = 1'b1;
         2'b01: cca_level = rssi_below_thr;
         2'b10: cca_level = ~receiving_packet;
         2'b11: cca_level = rssi_below_thr & ~receiving_packet;
      endcase
   end

   // Low selector sources, indexed by code 0x00..0x0F
   wire logic pq_reached = preamble_quality > preamble_quality_threshold;
   wire logic [15:0] src_vec = {
      crc_ok_reg & legacy_compat_enable,
      rssi_above_cs,
      serial_async_data,
      serial_sync_data,
      serial_clk,
      synth_lock,
      cca_level,
      pq_reached,
      crc_pkt_reg & legacy_compat_enable,
      sync_reg,
      tx_unf_reg,
      rx_ovf_reg,
      tx_full_reg,
      tx_fifo_at_thr,
      rx_thr_eop_reg,
      rx_fifo_at_thr
   };

   // Pin a and pin c force to the inversion level, pin b to its complement
   rsm_pin_mux #(.SLEEP_LEVEL_INV(1'b0), .CONFIG_RST(PIN_A_CONFIG_RST))
   u_pin_a (
      .clk(clk),
      .nrst(nrst),
      .config_in(pin_a_config),
      .sleep_hold(sleep_hold_reg),
      .src_vec(src_vec),
      .chip_ready_low(rdy_sync_reg),
      .clk_div_out(div_clk_reg),
      .pin_out(gp_out_a),
      .pin_oe(gp_out_a_oe),
      .temp_sense_en(temp_sensor_en)
   );

   rsm_pin_mux #(.SLEEP_LEVEL_INV(1'b1), .CONFIG_RST(PIN_B_CONFIG_RST))
   u_pin_b (
      .clk(clk),
      .nrst(nrst),
      .config_in({1'b0, pin_b_config[6:0]}),
      .sleep_hold(sleep_hold_reg),
      .src_vec(src_vec),
      .chip_ready_low(rdy_sync_reg),
      .clk_div_out(div_clk_reg),
      .pin_out(gp_out_b),
      .pin_oe(gp_out_b_oe),
      .temp_sense_en()
   );

   rsm_pin_mux #(.SLEEP_LEVEL_INV(1'b0), .CONFIG_RST(PIN_C_CONFIG_RST))
   u_pin_c (
      .clk(clk),
      .nrst(nrst),
      .config_in({1'b0, pin_c_config[6:0]}),
      .sleep_hold(sleep_hold_reg),
      .src_vec(src_vec),
      .chip_ready_low(rdy_sync_reg),
      .clk_div_out(div_clk_reg),
      .pin_out(gp_out_c),
      .pin_oe(gp_out_c_oe),
      .temp_sense_en()
   );
endmodule

/* verif/rsm_properties.sv */
// Checker for the radio status output mux, bound to rsm_top.
// Assumes one clock and the asynchronous active-low reset of the top.
`timescale 1ns/1ps
module rsm_properties
   import rsm_pkg::*;
#(
   parameter int DIV_RATIO = CLK_DIV_RATIO
)
(
   input wire logic clk,
   input wire logic nrst,
   input wire logic [7:0] pin_a_config,
   input wire logic [7:0] pin_b_config,
   input wire logic [7:0] pin_c_config,
   input wire logic sleep_state,
   input wire logic chip_ready_low,
   input wire logic rx_fifo_at_thr,
   input wire logic rx_fifo_overflow,
   input wire logic rx_fifo_flush,
   input wire logic gp_out_a,
   input wire logic gp_out_a_oe,
   input wire logic gp_out_b,
   input wire logic gp_out_b_oe,
   input wire logic gp_out_c,
   input wire logic temp_sensor_en
);
   localparam int HALF_M1 = DIV_RATIO / 2 - 1;
   logic [2:0] awake_reg;
   logic awake;
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Cycles since sleep ended and chip ready fell; the ready synchroniser needs a few
   always_ff @(posedge clk or negedge nrst)
      if (!nrst || sleep_state || chip_ready_low)
         awake_reg <= 3'h0;
      else if (!awake)
         awake_reg <= awake_reg + 3'h1;
   assign awake = awake_reg == 3'h7;
   a_rx_thr_level: assert property (
      awake && $past(pin_c_config) == 8'h00 |-> gp_out_c == $past(rx_fifo_at_thr))
      else $error("pin c misses fifo level");
   a_const_inv: assert property (
      $past(nrst) && $past(pin_c_config[5:0]) == 6'h2f
      |-> gp_out_c == $past(pin_c_config[6])) else $error("pin c constant");
   a_hiz_pin_b: assert property (
      $past(nrst) && $past(pin_b_config[5:0]) == 6'h2e |-> !gp_out_b_oe)
      else $error("pin b driven");
   a_temp_mode: assert property (
      $past(nrst) && $past(pin_a_config) == 8'h80
      |-> temp_sensor_en && !gp_out_a_oe) else $error("temp mode");
   a_sleep_force: assert property (
      $past(nrst, 2) && $past(nrst) && $past(sleep_state, 2)
      && $past(pin_c_config[5:0]) < 6'h20 && $past(pin_b_config[5:0]) < 6'h20
      |-> gp_out_c == $past(pin_c_config[6])
      && gp_out_b != $past(pin_b_config[6])) else $error("sleep level");
   a_ovf_set: assert property (
      awake && rx_fifo_overflow && !rx_fifo_flush
      ##1 !rx_fifo_flush && pin_c_config == 8'h04 |-> ##1 gp_out_c)
      else $error("overflow not shown");
   a_flush_clear: assert property (
      awake && rx_fifo_flush && !rx_fifo_overflow
      ##1 !rx_fifo_overflow && pin_c_config == 8'h04 |-> ##1 !gp_out_c)
      else $error("flush not shown");
   a_div_half: assert property (
      awake && $rose(gp_out_a) && pin_a_config == 8'h3f
      |-> ##HALF_M1 gp_out_a ##1 !gp_out_a) else $error("divider period");
   // Main scenarios reached
   c_ovf: cover property (pin_c_config == 8'h04 && gp_out_c);
   c_sleep: cover property (sleep_state ##2 sleep_state);
   c_temp: cover property (temp_sensor_en);
endmodule

bind rsm_top rsm_properties #(.DIV_RATIO(DIV_RATIO)) i_rsm_properties (.*);

/* verif/rsm_host_model.sv */
// Host microcontroller model watching the status pins.
// Assumes it shares clk with the block and needs no reset.
`timescale 1ns/1ps
module rsm_host_model
(
   input wire logic clk,
   input wire logic spi_busy,
   input wire logic gp_out_b,
   input wire logic pin_b_valid,
   input wire logic gp_out_c,
   output logic chip_select_low = 1'b1,
   output logic b_seen = 1'b0,
   output logic lock_irq = 1'b0
);
   logic c_q = 1'b0;
   // Pin b doubles as serial data, so it is read only when deselected
   always @(posedge clk)
   begin
      chip_select_low <= !spi_busy;
      if (pin_b_valid)
         b_seen <= gp_out_b;
   end
   // Lock taken from a rising edge, as an interrupt input would
   always @(posedge clk)
   begin
      c_q <= gp_out_c;
      lock_irq <= gp_out_c && !c_q;
   end
endmodule

/* verif/rsm_top_bench.sv */
// Self-checking bench for the radio status output mux and host model.
// Assumes a divider of 4 so the divided clock shows quickly.
`timescale 1ns/1ps
module rsm_top_bench;
   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic sleep_state = 1'b0;
   logic chip_ready_low = 1'b0;
   logic spi_busy = 1'b0;
   logic [7:0] pin_a_config = 8'h3f;
   logic [7:0] pin_b_config = 8'h2e;
   logic [7:0] pin_c_config = 8'h29;
   logic [42:0] ev = 43'h0;
   logic [7:0] preamble_quality, preamble_quality_threshold;
   logic [1:0] clear_channel_mode;
   logic rx_fifo_at_thr, rx_fifo_empty, rx_end_of_packet, rx_fifo_overflow;
   logic rx_fifo_flush, rx_fifo_first_read, tx_fifo_at_thr, tx_fifo_full;
   logic tx_fifo_underflow, tx_fifo_flush, sync_word_done, packet_end;
   logic addr_check_fail, tx_mode, crc_compare_done, crc_match, rx_mode_enter;
   logic legacy_compat_enable, rssi_below_thr, receiving_packet, rssi_above_cs;
   logic synth_lock, serial_clk, serial_sync_data, serial_async_data;
   logic gp_out_a, gp_out_a_oe, gp_out_b, gp_out_b_oe, gp_out_c, gp_out_c_oe;
   logic temp_sensor_en, pin_b_valid, chip_select_low, b_seen, lock_irq;
   logic [31:0] r;
   logic [5:0] sb, sc;
   integer seed = 66;
   int fail_count = 0;
   int checks = 0;
   // Level sources, then the sticky cases: select, hold, set, clear
   logic [5:0] lv [10] = '{6'h00, 6'h02, 6'h08, 6'h09, 6'h0a, 6'h0b,
      6'h0c, 6'h0d, 6'h0e, 6'h2f};
   logic [5:0] ss [7] = '{6'h04, 6'h05, 6'h06, 6'h01, 6'h03, 6'h07, 6'h0f};
   logic [17:0] sh [7] = '{18'h0, 18'h0, 18'h0, 18'h0, 18'h40, 18'h20000,
      18'h20000};
   logic [17:0] st [7] = '{18'h8, 18'h100, 18'h400, 18'h4, 18'hc0,
      18'h2c004, 18'h2c000};
   logic [17:0] sl [7] = '{18'h10, 18'h200, 18'h800, 18'h2, 18'h0,
      18'h20020, 18'h30000};
   // One stimulus word carries every radio status input
   assign {preamble_quality, preamble_quality_threshold, clear_channel_mode,
      serial_async_data, serial_sync_data, serial_clk, synth_lock,
      rssi_above_cs, receiving_packet, rssi_below_thr, legacy_compat_enable,
      rx_mode_enter, crc_match, crc_compare_done, tx_mode, addr_check_fail,
      packet_end, sync_word_done, tx_fifo_flush, tx_fifo_underflow,
      tx_fifo_full, tx_fifo_at_thr, rx_fifo_first_read, rx_fifo_flush,
      rx_fifo_overflow, rx_end_of_packet, rx_fifo_empty, rx_fifo_at_thr} = ev;
   rsm_top #(.DIV_RATIO(4)) i_rsm_top (.*);
   rsm_host_model i_rsm_host_model (.*);
   always #4 clk = ~clk;
   task automatic chk(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp)
      begin
         $display("wrong value %s expected %b seen %b", what, exp, got);
         fail_count++;
      end
   endtask
   // Expected level of a plain selected source, before inversion
   function automatic logic lvl(input logic [5:0] sel, input logic [42:0] e);
      case (sel)
         6'h00: return e[0];
         6'h02: return e[6];
         6'h08: return e[42:35] > e[34:27];
         6'h09: return (e[26] ? !e[19] : 1'b1) && (e[25] ? e[18] : 1'b1);
         6'h0a: return e[21];
         6'h0b: return e[22];
         6'h0c: return e[23];
         6'h0d: return e[24];
         6'h0e: return e[20];
         default: return 1'b0;
      endcase
   endfunction
   task automatic end_of_test();
      if (fail_count == 0 && checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   // Cut a hang short; the run needs under two thousand cycles
   initial
   begin
      #100000;
      fail_count++;
      end_of_test();
   end
   initial
   begin
      repeat (6) @(posedge clk);
      chk("b oe in reset", 1'b0, gp_out_b_oe);
      nrst <= 1'b1;
      repeat (20) @(posedge clk);
      pin_a_config <= 8'h80;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("b oe after reset", 1'b0, gp_out_b_oe);
      chk("temp enable", 1'b1, temp_sensor_en);
      repeat (150)
      begin
         @(posedge clk);
         r = $random(seed);
         sb = r[3:0] < 4'ha ? lv[r[3:0]] : {2'b01, r[3:0]};
         sc = r[7:4] < 4'ha ? lv[r[7:4]] : {2'b01, r[7:4]};
         pin_b_config <= {1'b0, r[8], sb};
         pin_c_config <= {1'b0, r[9], sc};
         spi_busy <= r[10];
         ev <= {r[31:21], $random(seed)};
         @(posedge clk);
         @(negedge clk);
         chk("gp_out_b", lvl(sb, ev) ^ r[8], gp_out_b);
         chk("gp_out_c", lvl(sc, ev) ^ r[9], gp_out_c);
         chk("gp_out_b_oe", 1'b1, gp_out_b_oe);
      end
      for (int i = 0; i < 7; i++)
      begin
         @(posedge clk);
         pin_c_config <= {2'b00, ss[i]};
         ev <= 43'(sl[i]);
         repeat (3) @(posedge clk);
         ev <= 43'(sh[i]);
         @(posedge clk);
         ev <= 43'(st[i]);
         @(posedge clk);
         ev <= 43'(sh[i]);
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk("sticky set", 1'b1, gp_out_c);
         @(posedge clk);
         ev <= 43'(sl[i]);
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk("sticky clear", 1'b0, gp_out_c);
      end
      @(posedge clk);
      pin_a_config <= 8'h6f;
      pin_b_config <= 8'h00;
      pin_c_config <= 8'h02;
      ev <= 43'h40;
      sleep_state <= 1'b1;
      chip_ready_low <= 1'b1;
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("b asleep", 1'b1, gp_out_b);
      chk("a asleep", 1'b1, gp_out_a);
      @(posedge clk);
      sleep_state <= 1'b0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("c held", 1'b0, gp_out_c);
      @(posedge clk);
      chip_ready_low <= 1'b0;
      pin_a_config <= 8'h3f;
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk("c woken", 1'b1, gp_out_c);
      // Host side: chip select gating of pin b and lock edge detection
      @(posedge clk);
      spi_busy <= 1'b1;
      pin_c_config <= 8'h0a;
      ev <= 43'h0;
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk("pin_b_valid", 1'b0, pin_b_valid);
      @(posedge clk);
      spi_busy <= 1'b0;
      ev <= 43'h200001;
      repeat (2) @(posedge clk);
      @(negedge clk);
      chk("lock_irq", 1'b1, lock_irq);
      repeat (4) @(posedge clk);
      @(negedge clk);
      chk("pin_b_valid", 1'b1, pin_b_valid);
      chk("b_seen", 1'b1, b_seen);
      repeat (20) @(posedge clk);
      end_of_test();
   end
endmodule
